// >>> common/rpfc_pkg.sv
// Constants, field layouts and carrier types of the receive frame filter
//////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Strip preamble and sync, queue payload only
// - Fixed format takes exactly payload_byte_limit bytes; limit 0 never ends the frame
// - Variable format loads length from first byte
// - Variable length above limit discards frame
// - Address is byte 1 variable, byte 0 fixed
// - Filter 01 accepts own station identifier only
// - Filter 10 accepts own or group identifier
// - Sync detection starts payload, raises frame match
// - Frames without sync dropped without any event
// - Limit 2047 disables length discard, length kept
// - Checksum appended after message on transmit
// - Receive compares checksum, check bytes never queued
// - Failed check clears queue, no available event
// - Keep failed bit retains payload, raises event
// - Select 0 CCITT seed 1D0F complemented, 1 alternate
// - Available event on event pin 0 when complete
// - Coding 01 Manchester, one is 10, zero 01
// - Manchester on payload and check bytes only
// - At most one balance coding method active
package rpfc_pkg;
  localparam int RPFC_LIMIT_W = 11;
  localparam int RPFC_SYNC_MAX = 8;
  localparam logic [10:0] RPFC_NO_LIMIT = 11'h7FF;
  localparam logic [10:0] RPFC_UNLIMITED = 11'h000;
  localparam logic [15:0] RPFC_CCITT_POLY = 16'h1021;
  localparam logic [15:0] RPFC_CCITT_SEED = 16'h1D0F;
  localparam logic [15:0] RPFC_ALT_POLY = 16'h8005;
  localparam logic [15:0] RPFC_ALT_SEED = 16'hFFFF;
  localparam logic [1:0] RPFC_FILT_OWN = 2'h1;
  localparam logic [1:0] RPFC_FILT_GROUP = 2'h2;
  localparam logic [1:0] RPFC_CODE_MANCH = 2'h1;
  localparam logic [2:0] RPFC_LAST_BIT = 3'h7;
  localparam logic [10:0] RPFC_ADDR_IDX_FIXED = 11'h000;
  localparam logic [10:0] RPFC_ADDR_IDX_VAR = 11'h001;
  localparam logic [63:0] RPFC_SHIFT_RST = 64'h0;
  localparam logic [15:0] RPFC_CRC_RST = 16'h0;

  // Configuration carried as one bundle
  typedef struct packed {
    logic var_format;
    logic [10:0] payload_byte_limit;
    logic [3:0] sync_bytes;
    logic [63:0] sync_pattern;
    logic [1:0] station_filter_select;
    logic [7:0] own_station_identifier;
    logic [7:0] group_station_identifier;
    logic check_enable_bit;
    logic keep_failed_frame_bit;
    logic crc_polynomial_select;
    logic [1:0] balance_coding_select;
  } rpfc_cfg_t;

  // Status flags carried as one bundle
  typedef struct packed {
    logic frame_match_flag;
    logic check_passed_flag;
    logic payload_available_event;
    logic queue_empty_flag;
    logic queue_full_flag;
    logic queue_threshold_flag;
  } rpfc_flags_t;
endpackage : rpfc_pkg

// >>> core/rpfc_rx_filter.sv
// Receive frame filter: sync hunt, length and address filtering, check, queue
//////////////////////////////////////////////////////////////////////////////
module rpfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys, // System clock
  input wire logic reset, // Synchronous reset
  input wire logic clr, // Flush all entries
  input wire logic in_valid, // Write request
  output logic in_ready, // Room for a word
  input wire logic [WIDTH-1:0] in_data, // Write data
  output logic out_valid, // Word available
  input wire logic out_ready, // Reader takes word
  output logic [WIDTH-1:0] out_data, // Head word
  output logic [$clog2(DEPTH):0] level // Words held
);
  import rpfc_pkg::*;
  localparam int AW = $clog2(DEPTH);

  // Refuse depths the pointer arithmetic cannot serve
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_depth
    $error("rpfc_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;

  assign in_ready = (cnt_reg != DEPTH[AW:0]);
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rd_reg];
  assign level = cnt_reg;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and count update, flush wins
  always_comb begin
    mem_next = mem_reg;
    wr_next = wr_reg;
    rd_next = rd_reg;
    cnt_next = cnt_reg;
    if (clr) begin
      wr_next = '0;
      rd_next = '0;
      cnt_next = '0;
    end else begin
      if (push) begin
        mem_next[wr_reg] = in_data;
        wr_next = wr_reg + 1'b1;
      end
      if (pop)
        rd_next = rd_reg + 1'b1;
      cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  // Registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
    mem_reg <= mem_next;
  end
endmodule : rpfc_fifo

//////////////////////////////////////////////////////////////////////////////
module rpfc_rx_filter #(
  parameter int DEPTH = 8
) (
  input wire logic clk_sys, // System clock, 40 MHz
  input wire logic reset, // Synchronous reset, active high
  input wire logic rx_enable, // Receive mode on
  input wire logic rx_chip, // Chip from bit synchronizer
  input wire logic rx_chip_valid, // Chip strobe
  output logic rx_chip_ready, // Chip accepted
  input wire rpfc_pkg::rpfc_cfg_t cfg, // Frame configuration
  input wire logic [$clog2(DEPTH):0] queue_threshold, // Threshold level
  output logic [7:0] rd_data, // Queue head byte
  output logic rd_valid, // Queue not empty
  input wire logic rd_ready, // Host pops byte
  output rpfc_pkg::rpfc_flags_t flags, // Status flags
  output logic event_pin_0 // Payload available
);
  import rpfc_pkg::*;

  typedef enum logic [1:0] {S_HUNT, S_BODY, S_CHECK} rpfc_state_t;

  // CRC over one byte, MSB first
  function automatic logic [15:0] crc_byte(logic [15:0] crc, logic [7:0] d, logic sel);
    logic [15:0] c;
    logic fb;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      fb = c[15] ^ d[i];
      c = {c[14:0], 1'b0} ^ (fb ? (sel ? RPFC_ALT_POLY : RPFC_CCITT_POLY) : 16'h0000);
    end
    return c;
  endfunction : crc_byte

  // Sync comparison over the configured number of bytes
  function automatic logic sync_hit(logic [63:0] sh, logic [63:0] pat, logic [3:0] n);
    logic [63:0] m;
    m = '0;
    for (int i = 0; i < RPFC_SYNC_MAX; i++)
      if (i < n)
        m[i*8 +: 8] = 8'hFF;
    return (n != 4'h0) && (((sh ^ pat) & m) == 64'h0);
  endfunction : sync_hit

  rpfc_state_t state_reg, state_next;
  logic [63:0] shift_reg, shift_next;
  logic half_reg, half_next, first_reg, first_next;
  logic [2:0] bit_reg, bit_next;
  logic [7:0] byte_reg, byte_next;
  logic [10:0] remain_reg, remain_next, idx_reg, idx_next;
  logic [15:0] crc_reg, crc_next, crx_reg, crx_next;
  logic ccnt_reg, ccnt_next;
  logic pend_reg, pend_next;
  logic [7:0] pdat_reg, pdat_next;
  logic match_reg, match_next, ok_reg, ok_next;
  logic arm_reg, arm_next, avail_reg, avail_next;
  logic take, manch, bit_ok, bit_val, byte_done, clr, wr_ready, q_empty;
  logic [7:0] byte_full;
  logic [15:0] crc_fin;
  logic [$clog2(DEPTH):0] q_level;

  assign rx_chip_ready = !(pend_reg && !wr_ready);
  assign take = rx_chip_valid && rx_chip_ready && rx_enable;
  assign manch = (cfg.balance_coding_select == RPFC_CODE_MANCH);
  assign byte_full = {byte_reg[6:0], bit_val};
  assign crc_fin = cfg.crc_polynomial_select ? crc_reg : ~crc_reg;

  // Chip to bit after sync (payload and check bytes): NRZ, or pairs of chips when Manchester is selected
  always_comb begin
    bit_ok = 1'b0;
    bit_val = rx_chip;
    half_next = half_reg;
    first_next = first_reg;
    if (take && state_reg != S_HUNT) begin
      if (manch) begin
        if (!half_reg) begin
          half_next = 1'b1;
          first_next = rx_chip;
        end else begin
          half_next = 1'b0;
          bit_ok = 1'b1;
          bit_val = first_reg;
        end
      end else begin
        bit_ok = 1'b1;
      end
    end
    if (state_reg == S_HUNT)
      half_next = 1'b0;
  end

  assign byte_done = bit_ok && (bit_reg == RPFC_LAST_BIT);

  // Frame sequencing
  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    bit_next = bit_reg;
    byte_next = byte_reg;
    remain_next = remain_reg;
    idx_next = idx_reg;
    crc_next = crc_reg;
    crx_next = crx_reg;
    ccnt_next = ccnt_reg;
    match_next = match_reg;
    ok_next = ok_reg;
    pend_next = pend_reg && !wr_ready;
    pdat_next = pdat_reg;
    arm_next = arm_reg && pend_reg;
    clr = 1'b0;
    if (bit_ok) begin
      byte_next = byte_full;
      bit_next = bit_reg + 3'h1;
    end
    unique case (state_reg)
      S_HUNT: begin
        // Preamble and noise shift through; no event until sync hits
        if (take) begin
          shift_next = {shift_reg[62:0], rx_chip};
          if (sync_hit(shift_next, cfg.sync_pattern, cfg.sync_bytes)) begin
            state_next = S_BODY;
            match_next = 1'b1;
            ok_next = 1'b0;
            arm_next = 1'b0;
            bit_next = '0;
            idx_next = '0;
            remain_next = cfg.payload_byte_limit;
            crc_next = cfg.crc_polynomial_select ? RPFC_ALT_SEED : RPFC_CCITT_SEED;
          end
        end
      end
      S_BODY: begin
        if (byte_done) begin
          // Every payload byte is queued, length and address included
          pend_next = 1'b1;
          pdat_next = byte_full;
          crc_next = crc_byte(crc_reg, byte_full, cfg.crc_polynomial_select);
          idx_next = (idx_reg == RPFC_NO_LIMIT) ? idx_reg : idx_reg + 11'h001;
          if (cfg.var_format && idx_reg == '0) begin
            remain_next = {3'h0, byte_full};
          end else if (!(cfg.payload_byte_limit == RPFC_UNLIMITED && !cfg.var_format)) begin
            remain_next = remain_reg - 11'h001;
          end
          // Length filter, disabled at the all-ones limit
          if (cfg.var_format && idx_reg == '0 && cfg.payload_byte_limit != RPFC_NO_LIMIT
              && {3'h0, byte_full} > cfg.payload_byte_limit) begin
            clr = 1'b1;
          end
          // Station filter on the address position
          if (idx_reg == (cfg.var_format ? RPFC_ADDR_IDX_VAR : RPFC_ADDR_IDX_FIXED)) begin
            if (cfg.station_filter_select == RPFC_FILT_OWN
                && byte_full != cfg.own_station_identifier)
              clr = 1'b1;
            if (cfg.station_filter_select == RPFC_FILT_GROUP
                && byte_full != cfg.own_station_identifier
                && byte_full != cfg.group_station_identifier)
              clr = 1'b1;
          end
          if (!clr && remain_next == '0
              && !(cfg.payload_byte_limit == RPFC_UNLIMITED && !cfg.var_format)) begin
            if (cfg.check_enable_bit) begin
              state_next = S_CHECK;
              ccnt_next = 1'b0;
            end else begin
              state_next = S_HUNT;
              arm_next = 1'b1;
              match_next = 1'b0;
              shift_next = RPFC_SHIFT_RST;
            end
          end
        end
      end
      S_CHECK: begin
        // Check bytes feed only the comparator, never the queue
        if (byte_done) begin
          crx_next = {crx_reg[7:0], byte_full};
          ccnt_next = 1'b1;
          if (ccnt_reg) begin
            ok_next = ({crx_reg[7:0], byte_full} == crc_fin);
            state_next = S_HUNT;
            match_next = 1'b0;
            shift_next = RPFC_SHIFT_RST;
            if (ok_next || cfg.keep_failed_frame_bit)
              arm_next = 1'b1;
            else
              clr = 1'b1;
          end
        end
      end
      default: begin
        state_next = S_HUNT;
      end
    endcase
    // Discarded frames leave nothing behind
    if (clr) begin
      pend_next = 1'b0;
      arm_next = 1'b0;
      if (state_reg == S_BODY) begin
        state_next = S_HUNT;
        match_next = 1'b0;
        shift_next = RPFC_SHIFT_RST;
      end
    end
    if (!rx_enable && state_reg != S_HUNT) begin
      state_next = S_HUNT;
      match_next = 1'b0;
      shift_next = RPFC_SHIFT_RST;
    end
  end

  // Event rises once the last byte is queued; holds until queue drains or the next sync hits
  always_comb begin
    avail_next = (arm_reg && !pend_reg) || (avail_reg && !q_empty);
    if (state_next == S_BODY && state_reg == S_HUNT)
      avail_next = 1'b0;
  end

  // Registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_reg <= S_HUNT;
      shift_reg <= RPFC_SHIFT_RST;
      half_reg <= 1'b0;
      first_reg <= 1'b0;
      bit_reg <= '0;
      byte_reg <= '0;
      remain_reg <= '0;
      idx_reg <= '0;
      crc_reg <= RPFC_CRC_RST;
      crx_reg <= RPFC_CRC_RST;
      ccnt_reg <= 1'b0;
      pend_reg <= 1'b0;
      pdat_reg <= '0;
      match_reg <= 1'b0;
      ok_reg <= 1'b0;
      arm_reg <= 1'b0;
      avail_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      half_reg <= half_next;
      first_reg <= first_next;
      bit_reg <= bit_next;
      byte_reg <= byte_next;
      remain_reg <= remain_next;
      idx_reg <= idx_next;
      crc_reg <= crc_next;
      crx_reg <= crx_next;
      ccnt_reg <= ccnt_next;
      pend_reg <= pend_next;
      pdat_reg <= pdat_next;
      match_reg <= match_next;
      ok_reg <= ok_next;
      arm_reg <= arm_next;
      avail_reg <= avail_next;
    end
  end

  // Payload queue toward the host
  rpfc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_queue (
    .clk_sys(clk_sys),
    .reset(reset),
    .clr(clr),
    .in_valid(pend_reg),
    .in_ready(wr_ready),
    .in_data(pdat_reg),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data),
    .level(q_level)
  );

  assign q_empty = !rd_valid;
  assign flags.frame_match_flag = match_reg;
  assign flags.check_passed_flag = ok_reg;
  assign flags.payload_available_event = avail_reg;
  assign flags.queue_empty_flag = q_empty;
  assign flags.queue_full_flag = !wr_ready;
  assign flags.queue_threshold_flag = (q_level > queue_threshold);
  assign event_pin_0 = avail_reg;
endmodule : rpfc_rx_filter

// >>> verif/rpfc_host_model.sv
// Host model: drains the receive queue promptly or slowly
module rpfc_host_model (
  input wire logic clk_sys, // Clock
  input wire logic reset, // Reset
  input wire logic stall, // Hold off reading
  input wire logic slow, // Pop every fourth cycle
  output logic rd_ready // Pop request
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_reg;
  // Pops only while allowed; slow mode spaces them out
  always_ff @(posedge clk_sys) begin
    cnt_reg <= reset ? 2'h0 : cnt_reg + 2'h1;
    rd_ready <= !reset && !stall && (!slow || cnt_reg == 2'h3);
  end
endmodule : rpfc_host_model

// >>> verif/rpfc_rx_filter_properties.sv
// Concurrent checks on the receive frame filter ports
module rpfc_rx_filter_properties #(
  parameter int DEPTH = 8
) (
  input wire logic clk_sys, // Clock
  input wire logic reset, // Reset
  input wire logic rx_enable, // Receive on
  input wire logic rx_chip, // Chip
  input wire logic rx_chip_valid, // Chip strobe
  input wire logic rx_chip_ready, // Chip taken
  input wire rpfc_pkg::rpfc_cfg_t cfg, // Setup
  input wire logic [$clog2(DEPTH):0] queue_threshold, // Threshold
  input wire logic [7:0] rd_data, // Head byte
  input wire logic rd_valid, // Not empty
  input wire logic rd_ready, // Pop
  input wire rpfc_pkg::rpfc_flags_t flags, // Flags
  input wire logic event_pin_0 // Event pin
);
  timeunit 1ns;
  timeprecision 1ps;
  import rpfc_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  // Stalled intake meets a pop; head byte left waiting
  sequence s_full_pop;
    !rx_chip_ready && rd_ready;
  endsequence
  sequence s_wait;
    rd_valid && !rd_ready;
  endsequence
  // Output relations
  a_event_pin:
    assert property (event_pin_0 == flags.payload_available_event)
    else $error("Event pin differs from flag");
  a_event_has_data:
    assert property ($rose(flags.payload_available_event) |-> rd_valid)
    else $error("Event raised with empty queue");
  a_empty_flag:
    assert property (flags.queue_empty_flag == !rd_valid)
    else $error("Empty flag wrong");
  a_stall_when_full:
    assert property (!rx_chip_ready |-> flags.queue_full_flag && rd_valid)
    else $error("Intake stalled without full queue");
  a_full_over_thresh:
    assert property (flags.queue_full_flag |-> flags.queue_threshold_flag
      || queue_threshold >= DEPTH)
    else $error("Full queue without threshold flag");
  a_pop_frees_intake:
    assert property (s_full_pop |=> rx_chip_ready)
    else $error("Intake still stalled after pop");
  a_head_holds:
    assert property (s_wait |=> !rd_valid || $stable(rd_data))
    else $error("Head byte changed without pop");
  a_check_needs_on:
    assert property ($rose(flags.check_passed_flag) |-> cfg.check_enable_bit)
    else $error("Check flag without checking");
  a_match_on_chip:
    assert property ($rose(flags.frame_match_flag)
      |-> $past(rx_enable) && $past(rx_chip_valid) && $past(rx_chip_ready))
    else $error("Frame match without taken chip");
  a_off_no_match:
    assert property (!rx_enable |=> !flags.frame_match_flag)
    else $error("Frame match while receive off");
endmodule : rpfc_rx_filter_properties

bind rpfc_rx_filter rpfc_rx_filter_properties #(.DEPTH(DEPTH)) u_props (
  .clk_sys(clk_sys), .reset(reset), .rx_enable(rx_enable), .rx_chip(rx_chip),
  .rx_chip_valid(rx_chip_valid), .rx_chip_ready(rx_chip_ready), .cfg(cfg),
  .queue_threshold(queue_threshold), .rd_data(rd_data), .rd_valid(rd_valid),
  .rd_ready(rd_ready), .flags(flags), .event_pin_0(event_pin_0)
);

// >>> verif/rpfc_rx_filter_tb.sv
// Self-checking bench: framed chips, host model, byte scoreboard
module rpfc_rx_filter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rpfc_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic rx_enable = 1'b0;
  logic rx_chip = 1'b0;
  logic rx_chip_valid = 1'b0;
  logic stall = 1'b1;
  logic slow = 1'b0;
  logic rx_chip_ready, rd_valid, rd_ready, event_pin_0;
  logic [7:0] rd_data;
  logic [15:0] sent_sync = 16'hA5C3;
  rpfc_cfg_t cfg = '0;
  rpfc_flags_t flags;
  logic [7:0] fb[$];
  logic [7:0] exp_q[$];
  logic [31:0] lfsr = 32'h675C28AF;
  int fail_count = 0;
  int checks = 0;

  always #12.5 clk_sys = ~clk_sys;

  rpfc_rx_filter #(.DEPTH(8)) u_dut (
    .clk_sys(clk_sys), .reset(reset), .rx_enable(rx_enable), .rx_chip(rx_chip),
    .rx_chip_valid(rx_chip_valid), .rx_chip_ready(rx_chip_ready), .cfg(cfg),
    .queue_threshold(4'h3), .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .flags(flags), .event_pin_0(event_pin_0)
  );
  rpfc_host_model u_host (
    .clk_sys(clk_sys), .reset(reset), .stall(stall), .slow(slow), .rd_ready(rd_ready)
  );
  ////////////////////////////////////////
  task automatic chk(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t ns: %s", $time, what);
    end
  endtask : chk

  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_step

  // Bitwise check sum over the frame bytes, MSB first
  function automatic logic [15:0] crc_of(input logic alt);
    logic [15:0] c;
    logic f;
    c = alt ? RPFC_ALT_SEED : RPFC_CCITT_SEED;
    foreach (fb[i]) begin
      for (int b = 7; b >= 0; b--) begin
        f = fb[i][b] ^ c[15];
        c = {c[14:0], 1'b0} ^ (f ? (alt ? RPFC_ALT_POLY : RPFC_CCITT_POLY) : 16'h0000);
      end
    end
    return alt ? c : ~c;
  endfunction : crc_of

  // One chip, held until taken at a rising edge
  task automatic chip(input logic c);
    rx_chip <= c;
    rx_chip_valid <= 1'b1;
    @(negedge clk_sys);
    while (rx_chip_ready !== 1'b1) @(negedge clk_sys);
    @(posedge clk_sys);
  endtask : chip

  task automatic send_byte(input logic [7:0] v, input logic man);
    for (int b = 7; b >= 0; b--) begin
      chip(v[b]);
      if (man) chip(!v[b]);
    end
  endtask : send_byte

  task automatic load(input logic [7:0] b0, input logic [7:0] b1, input int n);
    fb = {b0, b1};
    repeat (n) begin
      lfsr = lfsr_step(lfsr);
      fb.push_back(lfsr[7:0]);
    end
  endtask : load

  // Whole frame, then event and flag checks, then drain
  task automatic frame(input logic ok, input logic bad, input string name);
    logic [15:0] c;
    logic man;
    @(posedge clk_sys);
    man = cfg.balance_coding_select == RPFC_CODE_MANCH;
    c = crc_of(cfg.crc_polynomial_select) ^ {15'h0000, bad};
    if (ok) exp_q = {exp_q, fb};
    stall <= 1'b1;
    repeat (2) send_byte(8'hAA, 1'b0);
    send_byte(sent_sync[15:8], 1'b0);
    send_byte(sent_sync[7:0], 1'b0);
    foreach (fb[i]) send_byte(fb[i], man);
    if (cfg.check_enable_bit) begin
      send_byte(c[15:8], man);
      send_byte(c[7:0], man);
    end
    rx_chip_valid <= 1'b0;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(event_pin_0, ok, "payload event");
    chk(flags.check_passed_flag, ok & cfg.check_enable_bit & !bad, "check flag");
    chk(flags.queue_empty_flag, !ok, "queue state");
    chk(flags.frame_match_flag, 1'b0, "match cleared");
    @(posedge clk_sys);
    stall <= 1'b0;
    for (int i = 0; i < 200 && exp_q.size() != 0; i++) @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
    chk(exp_q.size() == 0, 1'b1, "queue drained");
    chk(flags.queue_empty_flag, 1'b1, "empty flag");
    $display("Test %s done", name);
  endtask : frame

  task automatic close_out();
    $display("Counts: %0d checks, %0d mismatches", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out
  ////////////////////////////////////////
  // Scoreboard: each popped byte against the oldest note
  always @(posedge clk_sys) begin
    if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
      if (exp_q.size() == 0) chk(1'b0, 1'b1, "unexpected byte");
      else chk(rd_data === exp_q.pop_front(), 1'b1, "payload byte");
    end
  end

  // Watchdog against a hang
  initial begin
    repeat (30000) @(posedge clk_sys);
    chk(1'b0, 1'b1, "watchdog expired");
    close_out();
  end

  // Main sequence
  initial begin
    cfg.var_format = 1'b1;
    cfg.payload_byte_limit = 11'h004;
    cfg.sync_bytes = 4'h2;
    cfg.sync_pattern = 64'hA5C3;
    cfg.station_filter_select = RPFC_FILT_OWN;
    cfg.own_station_identifier = 8'h3C;
    cfg.group_station_identifier = 8'hF0;
    cfg.check_enable_bit = 1'b1;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    rx_enable <= 1'b1;
    load(8'h03, 8'h3C, 2);
    frame(1'b1, 1'b0, "ccitt");
    cfg.crc_polynomial_select <= 1'b1;
    load(8'h02, 8'h3C, 1);
    frame(1'b1, 1'b0, "alt poly");
    load(8'h02, 8'hF0, 1);
    frame(1'b0, 1'b0, "own only");
    cfg.station_filter_select <= RPFC_FILT_GROUP;
    load(8'h02, 8'hF0, 1);
    frame(1'b1, 1'b0, "group");
    load(8'h02, 8'h55, 1);
    frame(1'b0, 1'b0, "stranger");
    load(8'h05, 8'h3C, 4);
    frame(1'b0, 1'b0, "too long");
    load(8'h04, 8'h3C, 3);
    frame(1'b1, 1'b0, "at limit");
    cfg.payload_byte_limit <= RPFC_NO_LIMIT;
    load(8'h06, 8'h3C, 5);
    frame(1'b1, 1'b0, "no limit");
    load(8'h03, 8'h3C, 2);
    frame(1'b0, 1'b1, "bad check");
    cfg.keep_failed_frame_bit <= 1'b1;
    load(8'h03, 8'hF0, 2);
    frame(1'b1, 1'b1, "kept");
    sent_sync = 16'hA5C2;
    load(8'h02, 8'h3C, 1);
    frame(1'b0, 1'b0, "foreign sync");
    sent_sync = 16'hA5C3;
    rx_enable <= 1'b0;
    frame(1'b0, 1'b0, "receive off");
    rx_enable <= 1'b1;
    cfg.var_format <= 1'b0;
    cfg.payload_byte_limit <= 11'h003;
    cfg.balance_coding_select <= RPFC_CODE_MANCH;
    cfg.crc_polynomial_select <= 1'b0;
    load(8'h3C, 8'hA7, 1);
    frame(1'b1, 1'b0, "fixed coded");
    load(8'h11, 8'h3C, 1);
    frame(1'b0, 1'b0, "fixed address");
    cfg.var_format <= 1'b1;
    cfg.payload_byte_limit <= RPFC_NO_LIMIT;
    cfg.balance_coding_select <= 2'h0;
    cfg.station_filter_select <= 2'h0;
    slow <= 1'b1;
    load(8'h0A, 8'h01, 9);
    fork
      begin
        repeat (400) @(negedge clk_sys);
        chk(rx_chip_ready, 1'b0, "intake stalled");
        chk(flags.queue_full_flag, 1'b1, "queue full");
        chk(flags.queue_threshold_flag, 1'b1, "threshold flag");
        chk(flags.frame_match_flag, 1'b1, "frame match");
        @(posedge clk_sys);
        stall <= 1'b0;
        repeat (24) @(posedge clk_sys);
        stall <= 1'b1;
      end
    join_none
    frame(1'b1, 1'b0, "full queue");
    close_out();
  end
endmodule : rpfc_rx_filter_tb
